// >>> transfer_consts.svh
// Constants of the automatic transfer sequencer: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the package and the design files.
`ifndef TRANSFER_CONSTS_SVH
`define TRANSFER_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define REG_CONTROL 12'h000
`define REG_STATUS 12'h004
`define REG_IRQ_STATUS 12'h008
`define REG_IRQ_MASK 12'h00c

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define CTL_MANUAL 0
`define CTL_SELECT_GEN 1
`define CTL_BUTTON_ON 2
`define CTL_BUTTON_OFF 3
`define CTL_TEST 4
`define CTL_RESET 32'h0000_0000

// ----------------------------------------------------------------------
// Interrupt bit positions
// ----------------------------------------------------------------------
`define IRQ_NET_FAIL 0
`define IRQ_NET_BACK 1
`define IRQ_ON_GEN 2
`define IRQ_ON_NET 3
`define IRQ_WIDTH 4
`define IRQ_RESET 4'h0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_MHZ 200
`define TICK_US 1
`define TICK_CYCLES (`TICK_US * `CLK_MHZ)

`endif

// >>> transfer_pkg.sv
// Types of the automatic transfer sequencer.
// Assumes transfer_consts.svh is on the include path.
`include "transfer_consts.svh"

package transfer_pkg;

   // Sequencer states, one-hot
   typedef enum logic [7:0] {
      st_init = 8'h01,
      st_on_net = 8'h02,
      st_open_net = 8'h04,
      st_close_gen = 8'h08,
      st_on_gen = 8'h10,
      st_open_gen = 8'h20,
      st_close_net = 8'h40,
      st_manual = 8'h80
   } seq_state_t;

   // Field inputs from monitors and breaker contacts
   typedef struct packed {
      logic [2:0] net_phase_ok;
      logic [2:0] gen_phase_ok;
      logic net_breaker_closed;
      logic net_breaker_open;
      logic generator_breaker_closed;
      logic generator_breaker_open;
   } field_in_t;

   // Commands to the breakers, generator and selector
   typedef struct packed {
      logic net_breaker_close;
      logic net_breaker_trip;
      logic generator_breaker_close;
      logic generator_breaker_trip;
      logic generator_request;
      logic actuator_supply_selector;
   } field_out_t;

endpackage : transfer_pkg

// >>> supply_monitor.sv
// Three-phase supply monitor: reports the supply available as one digital level.
// Assumes phase inputs are synchronous to aclk.
`timescale 1ns/1ps
`default_nettype none

module supply_monitor
   import transfer_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [2:0] phase_ok,
   output logic available
);

   // ----------------------------------------------------------------------
   // Availability
   // ----------------------------------------------------------------------
   // available only when all three phases are present
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         available <= 1'b0;
      else
         available <= &phase_ok;
   end

endmodule : supply_monitor

`default_nettype wire

// >>> transfer_sequencer.sv
// Automatic transfer sequencer between public net and generator, with AXI4-Lite registers.
// Assumes field inputs synchronous to aclk and a well-behaved AXI4-Lite master.
`timescale 1ns/1ps
`default_nettype none
`include "transfer_consts.svh"

module transfer_sequencer
   import transfer_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire field_in_t field_in,
   output field_out_t field_out,
   output logic irq
);

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   seq_state_t state;
   seq_state_t next_state;
   logic net_ok;
   logic gen_ok;
   logic [31:0] control;
   logic [`IRQ_WIDTH-1:0] irq_status;
   logic [`IRQ_WIDTH-1:0] irq_mask;
   logic [`IRQ_WIDTH-1:0] events;
   logic [11:0] aw_addr;
   logic aw_held;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic w_held;
   logic wr_fire;
   logic [31:0] wr_bytes;
   logic test_run;
   logic want_net_close;
   logic want_gen_close;
   logic want_net_trip;
   logic want_gen_trip;
   logic want_request;
   logic manual;
   logic settled;

   // ----------------------------------------------------------------------
   // Supply monitors
   // ----------------------------------------------------------------------
   // Net side monitor
   supply_monitor net_supply_monitor (
      .aclk(aclk),
      .aresetn(aresetn),
      .phase_ok(field_in.net_phase_ok),
      .available(net_ok)
   );

   // Generator side monitor
   supply_monitor generator_supply_monitor (
      .aclk(aclk),
      .aresetn(aresetn),
      .phase_ok(field_in.gen_phase_ok),
      .available(gen_ok)
   );

   // ----------------------------------------------------------------------
   // AXI4-Lite write path
   // ----------------------------------------------------------------------
   assign wr_fire = aw_held && w_held && !s_axi_bvalid;

   // Byte-lane mask from strobes
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1)
      begin : g_lane
         assign wr_bytes[gi*8 +: 8] = {8{w_strb[gi]}};
      end
   endgenerate

   // Address and data capture, either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 12'h000;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end
      else
      begin
         s_axi_awready <= !aw_held && !s_axi_awready;
         s_axi_wready <= !w_held && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_fire)
         begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
         end
      end
   end

   // Write response, slverr for unmapped
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end
      else if (wr_fire)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (aw_addr == `REG_CONTROL || aw_addr == `REG_IRQ_STATUS
                         || aw_addr == `REG_IRQ_MASK) ? 2'b00 : 2'b10;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // Control register; buttons self-clear after one cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         control <= `CTL_RESET;
      else if (wr_fire && aw_addr == `REG_CONTROL)
         control <= (control & ~wr_bytes) | (w_data & wr_bytes);
      else
      begin
         control[`CTL_BUTTON_ON] <= 1'b0;
         control[`CTL_BUTTON_OFF] <= 1'b0;
      end
   end

   // Interrupt mask register
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq_mask <= `IRQ_RESET;
      else if (wr_fire && aw_addr == `REG_IRQ_MASK && w_strb[0])
         irq_mask <= w_data[`IRQ_WIDTH-1:0];
   end

   // Sticky status, write one clears, set wins
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq_status <= `IRQ_RESET;
      else if (wr_fire && aw_addr == `REG_IRQ_STATUS && w_strb[0])
         irq_status <= (irq_status & ~w_data[`IRQ_WIDTH-1:0]) | events;
      else
         irq_status <= irq_status | events;
   end

   // Level interrupt
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq <= 1'b0;
      else
         irq <= |(irq_status & irq_mask);
   end

   // ----------------------------------------------------------------------
   // AXI4-Lite read path
   // ----------------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'b00;
      end
      else
      begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            case (s_axi_araddr)
               `REG_CONTROL: s_axi_rdata <= control;
               `REG_STATUS: s_axi_rdata <= {16'h0000, state, 2'b00, test_run,
                  field_out.generator_request, field_in.generator_breaker_closed,
                  field_in.net_breaker_closed, gen_ok, net_ok};
               `REG_IRQ_STATUS: s_axi_rdata <= {28'h0000000, irq_status};
               `REG_IRQ_MASK: s_axi_rdata <= {28'h0000000, irq_mask};
               default:
               begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= 2'b10;
               end
            endcase
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------------
   assign manual = control[`CTL_MANUAL];
   assign test_run = control[`CTL_TEST];

   // Next state from monitors and contacts
   always_comb
   begin
      next_state = state;
      case (state)
         // state from monitors
         // Monitors show their reset value for one cycle; decide after that
         st_init:
            if (settled)
               next_state = net_ok ? st_close_net : st_open_net;
         st_on_net:
            if (!net_ok || test_run)
               next_state = st_open_net;
         st_open_net:
            if (field_in.net_breaker_open && gen_ok)
               next_state = st_close_gen;
         st_close_gen:
            if (field_in.generator_breaker_closed)
               next_state = st_on_gen;
         st_on_gen:
            if (net_ok && !test_run)
               next_state = st_open_gen;
         st_open_gen:
            if (field_in.generator_breaker_open)
               next_state = st_close_net;
         st_close_net:
            if (field_in.net_breaker_closed)
               next_state = st_on_net;
         st_manual: next_state = st_manual;
         default: next_state = st_init;
      endcase
      if (manual)
         next_state = st_manual;
      else if (state == st_manual)
         next_state = st_init;
   end

   // State register, and a flag that marks the monitors as settled
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state <= st_init;
         settled <= 1'b0;
      end
      else
      begin
         state <= next_state;
         settled <= 1'b1;
      end
   end

   // Wanted commands per state
   always_comb
   begin
      want_net_close = state == st_close_net;
      want_gen_close = state == st_close_gen || state == st_on_gen;
      want_net_trip = state == st_open_net || state == st_close_gen || state == st_on_gen;
      want_gen_trip = state == st_open_gen || state == st_close_net || state == st_on_net;
      want_request = state == st_open_net || state == st_close_gen || state == st_on_gen
                     || state == st_open_gen
                     || (state == st_close_net && field_out.generator_request);
      // Buttons act as soon as manual is set, so a press in the entry write counts
      if (manual)
      begin
         want_net_close = !control[`CTL_SELECT_GEN] && control[`CTL_BUTTON_ON];
         want_net_trip = !control[`CTL_SELECT_GEN] && control[`CTL_BUTTON_OFF];
         want_gen_close = control[`CTL_SELECT_GEN] && control[`CTL_BUTTON_ON];
         want_gen_trip = control[`CTL_SELECT_GEN] && control[`CTL_BUTTON_OFF];
         want_request = field_out.generator_request;
      end
   end

   // Registered commands with close interlock
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         field_out <= '0;
      else
      begin
         field_out.net_breaker_close <= want_net_close && field_in.generator_breaker_open;
         field_out.generator_breaker_close <= want_gen_close && field_in.net_breaker_open
                                             && gen_ok;
         field_out.net_breaker_trip <= want_net_trip;
         field_out.generator_breaker_trip <= want_gen_trip;
         field_out.generator_request <= want_request;
         field_out.actuator_supply_selector <= gen_ok;
      end
   end

   // Interrupt events
   always_comb
   begin
      events = '0;
      events[`IRQ_NET_FAIL] = state == st_on_net && next_state == st_open_net;
      events[`IRQ_NET_BACK] = state == st_on_gen && next_state == st_open_gen;
      events[`IRQ_ON_GEN] = state == st_close_gen && next_state == st_on_gen;
      events[`IRQ_ON_NET] = state == st_close_net && next_state == st_on_net;
   end

endmodule : transfer_sequencer

`default_nettype wire

// >>> transfer_sequencer_chk.sv
// Checker for the transfer sequencer field commands.
// Assumes it is bound to transfer_sequencer and sees its ports only.
`timescale 1ns/1ps
`default_nettype none

module transfer_sequencer_chk
   import transfer_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire field_in_t field_in,
   input wire field_out_t field_out,
   input wire logic irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // ------------------------------------------------------------
   // Sequencing and interlock properties
   // ------------------------------------------------------------
   a_reset_quiet: assert property (disable iff (1'b0)
      !aresetn |=> !field_out.net_breaker_close && !field_out.generator_breaker_close
      && !field_out.generator_request) else $error("command active after reset");
   a_fail_trip: assert property ($fell(&field_in.net_phase_ok) &&
      field_in.net_breaker_closed |-> ##[1:5] field_out.net_breaker_trip
      && field_out.generator_request) else $error("net failure not acted on");
   a_same_step: assert property ($rose(field_out.generator_request)
      |-> field_out.net_breaker_trip) else $error("request without net trip");
   a_gen_gate: assert property (field_out.generator_breaker_close
      |-> $past(field_in.net_breaker_open)) else $error("generator close not gated");
   a_net_gate: assert property (field_out.net_breaker_close
      |-> $past(field_in.generator_breaker_open)) else $error("net close not gated");
   a_never_both: assert property (!(field_out.net_breaker_close
      && field_out.generator_breaker_close)) else $error("both closes active");
   a_net_back: assert property ($rose(field_out.generator_breaker_trip)
      |-> $past(&field_in.net_phase_ok, 2)) else $error("generator opened early");
   a_req_drop: assert property ($fell(field_out.generator_request)
      |-> $past(field_in.net_breaker_closed)) else $error("request dropped early");
   a_sel_follow: assert property ($rose(&field_in.gen_phase_ok)
      |-> ##[1:3] field_out.actuator_supply_selector) else $error("selector late");

   // Main scenarios reached
   c_on_gen: cover property ($rose(field_in.generator_breaker_closed));
   c_back: cover property ($fell(field_out.generator_request));
   c_irq: cover property ($rose(irq));
endmodule : transfer_sequencer_chk

`default_nettype wire

// >>> field_partner.sv
// Model of the two motorised breakers and the supply phases.
// Assumes commands from the sequencer; phases come from the bench.
`timescale 1ns/1ps
`default_nettype none

module field_partner
   import transfer_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire field_out_t cmd,
   input wire logic [2:0] net_ph,
   input wire logic [2:0] gen_ph,
   input wire logic slow,
   output field_in_t fin
);
   logic [1:0] closed;
   logic [1:0] move;
   logic [4:0] cnt [2];
   logic [4:0] dly;

   // Index 0 is the net breaker, index 1 the generator breaker
   assign move = {(cmd.generator_breaker_close && !closed[1]) ||
      (cmd.generator_breaker_trip && closed[1]),
      (cmd.net_breaker_close && !closed[0]) || (cmd.net_breaker_trip && closed[0])};
   assign dly = slow ? 5'h10 : 5'h02;

   // Spring mechanism: once a command starts the travel it always completes
   always_ff @(posedge aclk)
   begin
      for (int i = 0; i < 2; i++)
      begin
         if (!aresetn)
         begin
            cnt[i] <= 5'h00;
            closed[i] <= 1'b0;
         end
         else if (cnt[i] == dly)
         begin
            cnt[i] <= 5'h00;
            closed[i] <= !closed[i];
         end
         else if (move[i] || cnt[i] != 5'h00)
            cnt[i] <= cnt[i] + 5'h01;
      end
   end

   // Make and break contacts are complementary
   assign fin = {net_ph, gen_ph, closed[0], !closed[0], closed[1], !closed[1]};
endmodule : field_partner

`default_nettype wire

// >>> automatic_transfer_sequencer_bench.sv
// Self-checking bench of the transfer sequencer over AXI4-Lite.
// Assumes the package, constants header and field_partner are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "transfer_consts.svh"

module automatic_transfer_sequencer_bench
   import transfer_pkg::*;
;
   logic aclk = 1'b0;
   logic aresetn, slow, irq;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [2:0] net_ph, gen_ph;
   field_in_t field_in;
   field_out_t field_out;
   int failures, n_compared, cycles;

   always #2.5 aclk = ~aclk;

   transfer_sequencer u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .field_in, .field_out, .irq);
   field_partner u_field (.aclk, .aresetn, .cmd(field_out), .net_ph, .gen_ph, .slow,
      .fin(field_in));

   // ------------------------------------------------------------
   // Bus and compare tasks
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask : wr

   task automatic rdr(input logic [11:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask : rdr

   // Poll the status register until the masked field matches
   task automatic poll(input logic [31:0] m, input logic [31:0] e, input string what);
      for (int i = 0; i < 300; i++)
      begin
         rdr(`REG_STATUS);
         if ((rd & m) === e)
            break;
      end
      check(what, rd & m, e);
   endtask : poll

   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop

   // Hang guard
   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         failures++;
         report_and_stop();
      end
   end

   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial
   begin
      {aresetn, slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      net_ph = 3'h7;
      gen_ph = 3'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rdr(`REG_CONTROL);
      check("control reset", rd, 32'h0000_0000);
      rdr(`REG_IRQ_MASK);
      check("mask reset", rd, 32'h0000_0000);
      poll(32'hff1f, 32'h0000_0205, "start on net");
      check("irq idle", irq, 1'b0);
      check("selector on net", field_out.actuator_supply_selector, 1'b0);
      s_axi_wstrb <= 4'h0;
      wr(`REG_CONTROL, 32'h0000_0010);
      s_axi_wstrb <= 4'hf;
      rdr(`REG_CONTROL);
      check("strobe masked", rd, 32'h0000_0000);
      rdr(12'h010);
      check("unmapped resp", rsp, 2'h2);
      check("unmapped data", rd, 32'h0000_0000);
      wr(`REG_STATUS, 32'h0000_0000);
      check("status write", rsp, 2'h2);
      wr(`REG_IRQ_STATUS, 32'h0000_000f);
      wr(`REG_IRQ_MASK, 32'h0000_0005);
      $display("test reset done");
      net_ph <= 3'h5;
      poll(32'hff00, 32'h0000_0400, "net open");
      check("trip and request", {field_out.net_breaker_trip, field_out.generator_request},
         2'h3);
      check("irq fail", irq, 1'b1);
      gen_ph <= 3'h7;
      poll(32'hff0f, 32'h0000_100a, "on generator");
      check("selector", field_out.actuator_supply_selector, 1'b1);
      rdr(`REG_IRQ_STATUS);
      check("irq events", rd, 32'h0000_0005);
      wr(`REG_IRQ_STATUS, 32'h0000_0001);
      check("irq partial", irq, 1'b1);
      wr(`REG_IRQ_STATUS, 32'h0000_0004);
      check("irq cleared", irq, 1'b0);
      $display("test net failure done");
      slow <= 1'b1;
      net_ph <= 3'h7;
      poll(32'hff1f, 32'h0000_0207, "back on net");
      rdr(`REG_IRQ_STATUS);
      check("return events", rd, 32'h0000_000a);
      check("irq masked", irq, 1'b0);
      $display("test net return done");
      slow <= 1'b0;
      wr(`REG_CONTROL, 32'h0000_0010);
      poll(32'hff00, 32'h0000_1000, "test on gen");
      wr(`REG_CONTROL, 32'h0000_0000);
      poll(32'hff1f, 32'h0000_0207, "test end");
      $display("test function test done");
      wr(`REG_CONTROL, 32'h0000_0007);
      repeat (20) @(posedge aclk);
      check("gen close blocked", field_out.generator_breaker_close, 1'b0);
      poll(32'hff08, 32'h0000_8000, "manual hold");
      wr(`REG_CONTROL, 32'h0000_0009);
      poll(32'h0004, 32'h0000_0000, "net off");
      wr(`REG_CONTROL, 32'h0000_0007);
      poll(32'h0008, 32'h0000_0008, "gen on");
      wr(`REG_CONTROL, 32'h0000_000b);
      poll(32'h0008, 32'h0000_0000, "gen off");
      wr(`REG_CONTROL, 32'h0000_0000);
      poll(32'hff1f, 32'h0000_0207, "auto again");
      $display("test manual done");
      report_and_stop();
   end
endmodule : automatic_transfer_sequencer_bench

bind transfer_sequencer transfer_sequencer_chk u_chk (.aclk(aclk), .aresetn(aresetn),
   .field_in(field_in), .field_out(field_out), .irq(irq));

`default_nettype wire
